// ### include/adc_cal_cfg.svh
`ifndef ADC_CAL_CFG_SVH
`define ADC_CAL_CFG_SVH

// register addresses carried in the first four bits of a write frame
`define ADDR_CONTROL     4'h1
`define ADDR_OFFSET_A    4'h2
`define ADDR_OFFSET_B    4'h3
`define ADDR_GAIN_A      4'h4
`define ADDR_GAIN_B      4'h5
// read-back select codes in the control register
`define RD_RESULT        4'h0
// control register fields
`define CTRL_RD_MSB      11
`define CTRL_RD_LSB      8
`define CTRL_CAL_BIT     4
`define CTRL_GAIN_MSB    3
`define CTRL_GAIN_LSB    0
// gain register takes the seven bits just after the address
`define GAIN_DATA_MSB    11
`define GAIN_DATA_LSB    5
// reset values
`define CTRL_RESET       12'h000
`define OFFSET_RESET     12'h000
`define GAIN_RESET       7'h00
// serial clock falling edge numbers within a frame
`define EDGE_DIN_LAST    6'h10
`define EDGE_WRITE       6'h11
`define EDGE_FIRST_OUT   6'h13
`define EDGE_LINE_OFF    6'h2f
`define EDGE_SATURATE    6'h3f
// offset correction limit in lsb, 500
`define OFFSET_LIMIT     14'h01f4
// gain multiplier unity, 4096, and its shift
`define GAIN_UNITY       13'h1000
`define GAIN_SHIFT       12
// 14-bit two's complement output code bounds
`define CODE_MAX         18'h01fff
`define CODE_MIN         18'h3e000

`endif

// ### include/adc_cal_pkg.sv
package adc_cal_pkg;
  `include "adc_cal_cfg.svh"

  // one 14-bit code per channel, index 0 is channel a
  typedef struct packed {
    logic [1:0][13:0] code;
  } chan_pair_t;

  // one serial register write: address then data
  typedef struct packed {
    logic [3:0]  addr;
    logic [11:0] data;
  } wr_word_t;

  // frame sequencing on the system clock
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_HOLD
  } frame_state_t;
endpackage

// ### rtl/adc_offset_gain_calibration.sv
`timescale 1ns/10ps
// Operation
// - calibrate pin high: next frame calibrates
// - calibration spans frame, done after edge 19
// - pin held high: every frame calibrates
// - early pin gives bad frame, next fine
// - pin rising mid-conversion corrupts that result
// - pin low again: next frame converts normally
// - control cal bit starts calibration, corrupts current
// - calibration shorts inputs, stores offset codes
// - stored offset subtracted from every result
// - gain change keeps old offset, no recalibration
// - offset correction limited to 500 lsb on calibration; host offset writes not clamped
// - host may write offsets directly
// - separate gain register per channel
// - gain register: sign plus six-bit magnitude
// - each gain step is one part in 4096
// - each result scaled by its channel multiplier
// - zero gain register means unity scaling
// - sign 0 subtracts, sign 1 adds magnitude
// - write frame: address, data, commit at 17
// - gain write keeps seven bits after address
// - offset and gain registers reset to zero
module adc_offset_gain_calibration (
  // system clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // serial link pins
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    cal_pin,
  input  wire logic                    host_data_line,
  output logic                         result_line_a,
  output logic                         result_line_a_oe_n,
  output logic                         result_line_b,
  output logic                         result_line_b_oe_n,
  // converter core
  output logic                         sample_req,
  output logic                         short_inputs,
  input  wire logic                    raw_valid,
  input  wire adc_cal_pkg::chan_pair_t raw_sample,
  input  wire logic                    converters_powered,
  // front end and status
  output logic [3:0]                   pga_gain,
  output logic                         cal_active
);
  import adc_cal_pkg::*;

  // ---------------- link domain, falling edge of sclk ----------------
  logic             link_rst_n;      // cleared while frame select high
  logic             sclk_fall;       // inverted link clock for synchroniser
  logic [5:0]       edge_cnt;        // falling edges since frame start
  logic [5:0]       next_edge_cnt;
  logic [15:0]      shift_in;        // address and data from host
  logic [15:0]      next_shift_in;
  logic [27:0]      out_a;           // line a: first word then b
  logic [27:0]      next_out_a;
  logic [27:0]      out_b;           // line b: channel b then a
  logic [27:0]      next_out_b;
  logic             line_oe_n;       // shared line enable, low drives
  logic             next_line_oe_n;
  logic             conv_done;       // edge 19 reached in this frame
  logic             next_conv_done;
  logic             wr_tgl;          // flips on every committed write
  logic             next_wr_tgl;
  wr_word_t         wr_word;         // last committed write, held
  wr_word_t         next_wr_word;
  logic             ready_link;      // result ready, seen by link

  // ---------------- system domain ----------------
  logic [3:0]       pin_sync;        // {done, tgl, cal, cs} filtered
  logic             cs_s;            // frame select, synchronised
  logic             cal_s;           // calibrate pin, synchronised
  logic             tgl_s;           // write toggle, synchronised
  logic             done_s;          // conversion done, synchronised
  frame_state_t     state;
  frame_state_t     next_state;
  logic             cal_mode;        // this frame is a calibration
  logic             next_cal_mode;
  logic [11:0]      ctrl;            // control register
  logic [11:0]      next_ctrl;
  logic [1:0][11:0] offset;          // offset_correction_a and _b
  logic [1:0][11:0] next_offset;
  logic [1:0][6:0]  gain;            // gain_correction_a and _b
  logic [1:0][6:0]  next_gain;
  logic [1:0][11:0] cal_capture;     // measured offset awaiting commit
  logic [1:0][11:0] next_cal_capture;
  logic             cal_committed;   // commit done for this frame
  logic             next_cal_committed;
  chan_pair_t       result;          // corrected results
  chan_pair_t       next_result;
  logic [13:0]      word_a;          // line a word: result or readback
  logic [13:0]      next_word_a;
  logic             result_ready;    // result valid for the link
  logic             next_result_ready;
  logic             next_sample_req;
  logic             cs_prev;         // edge detect stores
  logic             cal_prev;
  logic             tgl_prev;
  logic             cs_fall;         // frame started
  logic             wr_event;        // new register write arrived
  logic             corrupt;         // conversion spoilt mid-flight
  logic [1:0][13:0] corrected;       // per channel corrected code
  logic [1:0][11:0] measured;        // per channel offset code

  // sign-magnitude offset subtraction then gain scaling, saturated
  function automatic logic [13:0] correct_code(
    input logic [13:0] raw,
    input logic [11:0] off,
    input logic [6:0]  gn
  );
    logic signed [17:0] diff;
    logic [12:0]        mult;
    logic signed [31:0] prod;
    logic signed [17:0] scaled;
    diff = $signed({{4{raw[13]}}, raw});
    if (off[11]) begin
      diff = diff + $signed({7'h00, off[10:0]});
    end else begin
      diff = diff - $signed({7'h00, off[10:0]});
    end
    if (diff > $signed(`CODE_MAX)) begin
      diff = $signed(`CODE_MAX);
    end else if (diff < $signed(`CODE_MIN)) begin
      diff = $signed(`CODE_MIN);
    end
    // top bit is the sign, six low bits the magnitude
    if (gn[6]) begin
      mult = `GAIN_UNITY + {7'h00, gn[5:0]};
    end else begin
      mult = `GAIN_UNITY - {7'h00, gn[5:0]};
    end
    prod   = 32'(diff) * $signed({19'h0_0000, mult});
    scaled = 18'(prod >>> `GAIN_SHIFT);
    if (scaled > $signed(`CODE_MAX)) begin
      scaled = $signed(`CODE_MAX);
    end else if (scaled < $signed(`CODE_MIN)) begin
      scaled = $signed(`CODE_MIN);
    end
    return scaled[13:0];
  endfunction

  // raw code to clamped sign-magnitude offset
  function automatic logic [11:0] offset_code(input logic [13:0] raw);
    logic [13:0] mag;
    mag = raw[13] ? 14'(-raw) : raw;
    if (mag > `OFFSET_LIMIT) begin
      mag = `OFFSET_LIMIT;
    end
    return {raw[13], mag[10:0]};
  endfunction

  assign link_rst_n = arst_n & ~cs_n;
  assign sclk_fall  = ~sclk;

  // link: edge count, host data shift, result shift out
  always_comb begin
    next_edge_cnt = edge_cnt;
    if (edge_cnt != `EDGE_SATURATE) begin
      next_edge_cnt = edge_cnt + 6'h01;
    end
    next_shift_in = shift_in;
    if (next_edge_cnt <= `EDGE_DIN_LAST) begin
      next_shift_in = {shift_in[14:0], host_data_line};
    end
    next_out_a     = out_a;
    next_out_b     = out_b;
    next_line_oe_n = line_oe_n;
    if (next_edge_cnt == `EDGE_FIRST_OUT) begin
      // load both lines at the first output edge
      next_out_a     = ready_link ? {word_a, result.code[1]} : '0;
      next_out_b     = ready_link ? {result.code[1], result.code[0]} : '0;
      next_line_oe_n = 1'b0;
    end else if (next_edge_cnt == `EDGE_LINE_OFF) begin
      // both words sent, release lines
      next_line_oe_n = 1'b1;
    end else if (next_edge_cnt > `EDGE_FIRST_OUT) begin
      next_out_a = {out_a[26:0], 1'b0};
      next_out_b = {out_b[26:0], 1'b0};
    end
    next_conv_done = conv_done | (next_edge_cnt >= `EDGE_FIRST_OUT);
  end

  // link frame registers, cleared by frame select high
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      edge_cnt  <= 6'h00;
      shift_in  <= 16'h0000;
      out_a     <= '0;
      out_b     <= '0;
      line_oe_n <= 1'b1;
      conv_done <= 1'b0;
    end else begin
      edge_cnt  <= next_edge_cnt;
      shift_in  <= next_shift_in;
      out_a     <= next_out_a;
      out_b     <= next_out_b;
      line_oe_n <= next_line_oe_n;
      conv_done <= next_conv_done;
    end
  end

  // link: commit the write word one edge after the last data bit
  always_comb begin
    next_wr_tgl  = wr_tgl;
    next_wr_word = wr_word;
    if (next_edge_cnt == `EDGE_WRITE && cs_n == 1'b0) begin
      next_wr_tgl  = ~wr_tgl;
      next_wr_word = shift_in;
    end
  end

  // write word survives between frames
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_tgl  <= 1'b0;
      wr_word <= '0;
    end else begin
      wr_tgl  <= next_wr_tgl;
      wr_word <= next_wr_word;
    end
  end

  assign result_line_a      = out_a[27];
  assign result_line_b      = out_b[27];
  assign result_line_a_oe_n = line_oe_n;
  assign result_line_b_oe_n = line_oe_n;

  // result ready level into the link domain
  sync_filter #(.W(1), .INIT(1'b0)) u_ready_sync (
    .clk    (sclk_fall),
    .arst_n (arst_n),
    .din    (result_ready),
    .dout   (ready_link)
  );

  // pins and link levels into the system domain
  sync_filter #(.W(4), .INIT(4'b0001)) u_pin_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({conv_done, wr_tgl, cal_pin, cs_n}),
    .dout   (pin_sync)
  );
  assign {done_s, tgl_s, cal_s, cs_s} = pin_sync;

  // per channel correction and offset measurement
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign corrected[i] = correct_code(raw_sample.code[i], offset[i],
                                       gain[i]);
    assign measured[i]  = offset_code(raw_sample.code[i]);
  end

  assign cs_fall  = cs_prev & ~cs_s;
  assign wr_event = tgl_s ^ tgl_prev;
  assign corrupt  = (state != ST_IDLE) & ~cal_mode & ~done_s &
                    ((cal_s & ~cal_prev) |
                     (wr_event & wr_word.addr == `ADDR_CONTROL &
                      wr_word.data[`CTRL_CAL_BIT]));

  // frame sequencing, calibration and register writes
  always_comb begin
    next_state         = state;
    next_cal_mode      = cal_mode;
    next_ctrl          = ctrl;
    next_offset        = offset;
    next_gain          = gain;
    next_cal_capture   = cal_capture;
    next_cal_committed = cal_committed;
    next_result        = result;
    next_result_ready  = result_ready;
    next_sample_req    = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (cs_fall) begin
          // pin or control bit selects a calibration frame
          // late pin spoils only this frame, each start re-samples it
          next_cal_mode      = cal_s | ctrl[`CTRL_CAL_BIT];
          next_cal_committed = 1'b0;
          next_sample_req    = 1'b1;
          next_state         = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (cs_s) begin
          next_state = ST_IDLE;
        end else if (raw_valid) begin
          if (cal_mode) begin
            next_cal_capture = measured;
          end else begin
            next_result       = corrected;
            next_result_ready = 1'b1;
          end
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cal_mode && done_s && !cal_committed) begin
          // offsets only taken with both converters powered
          next_cal_committed = 1'b1;
          if (converters_powered) begin
            next_offset               = cal_capture;
            next_ctrl[`CTRL_CAL_BIT] = 1'b0;
          end
        end
        if (cs_s) begin
          next_result_ready = 1'b0;
          next_state        = ST_IDLE;
        end
      end
    endcase
    if (corrupt) begin
      next_result = '0;
    end
    if (wr_event) begin
      // host write wins over calibration commit
      case (wr_word.addr)
        `ADDR_CONTROL:  next_ctrl      = wr_word.data;
        `ADDR_OFFSET_A: next_offset[0] = wr_word.data;
        `ADDR_OFFSET_B: next_offset[1] = wr_word.data;
        `ADDR_GAIN_A:   next_gain[0]   = wr_word.data[`GAIN_DATA_MSB:
                                                      `GAIN_DATA_LSB];
        `ADDR_GAIN_B:   next_gain[1]   = wr_word.data[`GAIN_DATA_MSB:
                                                      `GAIN_DATA_LSB];
        default: ;
      endcase
    end
    // read-back selection for line a
    case (ctrl[`CTRL_RD_MSB:`CTRL_RD_LSB])
      `RD_RESULT:     next_word_a = next_result.code[0];
      `ADDR_OFFSET_A: next_word_a = {2'b00, offset[0]};
      `ADDR_OFFSET_B: next_word_a = {2'b00, offset[1]};
      `ADDR_GAIN_A:   next_word_a = {7'h00, gain[0]};
      `ADDR_GAIN_B:   next_word_a = {7'h00, gain[1]};
      default:        next_word_a = 14'h0000;
    endcase
  end

  // system domain registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state         <= ST_IDLE;
      cal_mode      <= 1'b0;
      ctrl          <= `CTRL_RESET;
      offset        <= {2{`OFFSET_RESET}};
      gain          <= {2{`GAIN_RESET}};
      cal_capture   <= '0;
      cal_committed <= 1'b0;
      result        <= '0;
      word_a        <= 14'h0000;
      result_ready  <= 1'b0;
      sample_req    <= 1'b0;
      cs_prev       <= 1'b1;
      cal_prev      <= 1'b0;
      tgl_prev      <= 1'b0;
    end else begin
      state         <= next_state;
      cal_mode      <= next_cal_mode;
      ctrl          <= next_ctrl;
      offset        <= next_offset;
      gain          <= next_gain;
      cal_capture   <= next_cal_capture;
      cal_committed <= next_cal_committed;
      result        <= next_result;
      word_a        <= next_word_a;
      result_ready  <= next_result_ready;
      sample_req    <= next_sample_req;
      cs_prev       <= cs_s;
      cal_prev      <= cal_s;
      tgl_prev      <= tgl_s;
    end
  end

  assign short_inputs = (state != ST_IDLE) & cal_mode;
  assign cal_active   = short_inputs;
  assign pga_gain     = ctrl[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB];

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_PIN_STARTS_CAL:
    assert property (state == ST_IDLE && cs_fall && cal_s
                     |=> cal_mode && sample_req && short_inputs)
    else $error("pin high did not start a calibration frame");
  AST_PIN_HELD:
    assert property (state == ST_HOLD && cal_s ##1 state == ST_IDLE
                     ##[1:300] cs_fall && cal_s |=> cal_mode)
    else $error("held pin did not repeat calibration");
  AST_NORMAL_AFTER_CAL:
    assert property (state == ST_IDLE && cs_fall && !cal_s &&
                     !ctrl[`CTRL_CAL_BIT] |=> !cal_mode && !short_inputs)
    else $error("normal conversion expected");
  AST_BIT_STARTS_CAL:
    assert property (state == ST_IDLE && cs_fall && ctrl[`CTRL_CAL_BIT]
                     |=> cal_mode)
    else $error("control bit did not start calibration");
  AST_CORRUPT_CLEARS:
    assert property (corrupt |=> result == '0)
    else $error("corrupted conversion kept its result");
  AST_COMMIT_LIMIT:
    assert property ($rose(cal_committed) && $past(converters_powered)
                     |-> offset[0][10:0] <= 11'h1f4 &&
                         offset[1][10:0] <= 11'h1f4)
    else $error("calibrated offset exceeds limit");
  AST_UNITY_GAIN:
    assert property (state == ST_SAMPLE && raw_valid && !cal_mode &&
                     !cs_s && !corrupt && gain[0] == 7'h00 &&
                     offset[0] == 12'h000
                     |=> result.code[0] == $past(raw_sample.code[0]))
    else $error("zero gain register did not give unity");
  AST_GAIN_KEEPS_OFFSET:
    assert property ($changed(pga_gain) && !$past(cal_mode)
                     |-> $stable(offset))
    else $error("gain change altered stored offset");
  AST_GAIN_WRITE:
    assert property (wr_event && wr_word.addr == `ADDR_GAIN_A
                     |=> gain[0] == $past(wr_word.data[11:5]))
    else $error("gain write stored wrong bits");
  AST_WRITE_AT_17:
    assert property (@(negedge sclk) disable iff (!arst_n || cs_n)
                     edge_cnt == 6'h10 |=> wr_tgl != $past(wr_tgl))
    else $error("write not committed on edge 17");
  AST_LINES_AT_19:
    assert property (@(negedge sclk) disable iff (!arst_n || cs_n)
                     edge_cnt == 6'h12 |=> !line_oe_n && conv_done)
    else $error("lines not enabled on edge 19");

  COV_CAL_COMMIT:   cover property ($rose(cal_committed) && converters_powered);
  COV_NORMAL_FRAME: cover property ($rose(result_ready));
  COV_REG_WRITE:    cover property (wr_event);
  COV_CORRUPT:      cover property (corrupt);
endmodule

// ### rtl/sync_filter.sv
`timescale 1ns/10ps
// three-stage synchroniser; output follows once stages two and three agree
module sync_filter #(
  parameter int unsigned    W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // destination clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // foreign level in, filtered level out
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  logic [W-1:0] s1;            // first stage, read only by s2
  logic [W-1:0] s2;            // second stage
  logic [W-1:0] s3;            // third stage
  logic [W-1:0] next_dout;     // filtered value

  // per bit: take the level only when stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
    end
  end

  // chain registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1   <= INIT;
      s2   <= INIT;
      s3   <= INIT;
      dout <= INIT;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule

// ### test/adc_offset_gain_calibration_test.sv
`timescale 1ns/10ps
// bench: host model on the link, behavioural converter core on clk
module adc_offset_gain_calibration_test;
  import adc_cal_pkg::*;
  logic        clk, arst_n, raw_valid, powered, short_seen;
  wire         sclk, cs_n, cal_pin, din, line_a, line_b, oe_a_n, oe_b_n;
  wire         sample_req, short_inputs, cal_active;
  wire   [3:0] pga_gain;
  chan_pair_t  raw_sample, pend;
  logic [11:0] off_a, off_b;
  logic [6:0]  gn_a, gn_b;
  logic [27:0] q[$], expv;
  int          num_errors, tests_run, cyc, seed;

  host_port_model host (.sclk(sclk), .cs_n(cs_n), .cal_pin(cal_pin),
    .host_data_line(din), .result_line_a(line_a),
    .result_line_b(line_b));
  adc_offset_gain_calibration uut (.clk(clk), .arst_n(arst_n),
    .sclk(sclk), .cs_n(cs_n), .cal_pin(cal_pin), .host_data_line(din),
    .result_line_a(line_a), .result_line_a_oe_n(oe_a_n),
    .result_line_b(line_b), .result_line_b_oe_n(oe_b_n),
    .sample_req(sample_req), .short_inputs(short_inputs),
    .raw_valid(raw_valid), .raw_sample(raw_sample),
    .converters_powered(powered), .pga_gain(pga_gain),
    .cal_active(cal_active));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // core answers each sample request one cycle later
  always @(posedge clk) begin
    raw_valid <= sample_req;
    if (sample_req) raw_sample <= pend;
    if (raw_valid) short_seen <= short_inputs;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test;
    end
  end
  // compare one value, count it
  task automatic check(input string n, input logic [27:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  // expected corrected code: offset, then gain, then clamp
  function automatic logic [13:0] calc(logic [13:0] c, logic [11:0] o,
                                       logic [6:0] g);
    int v;
    v = $signed(c) + (o[11] ? int'(o[10:0]) : -int'(o[10:0]));
    v = (v * (4096 + (g[6] ? 1 : -1) * int'(g[5:0]))) >>> 12;
    return 14'(v > 8191 ? 8191 : (v < -8192 ? -8192 : v));
  endfunction
  // offset stored by calibration: sign-magnitude, clamped to 500
  function automatic logic [11:0] sm(logic [13:0] c);
    int v, m;
    v = $signed(c);
    m = v < 0 ? -v : v;
    if (m > 500) m = 500;
    return {v < 0, 11'(m)};
  endfunction
  // mode 0 normal, 1 zeros, 2 zeros and offsets stored, 3 max b
  task automatic xfer(input logic [3:0] ad, input logic [11:0] d,
                      input int md);
    logic [13:0] a, b;
    a = 14'($random(seed) % 1500);
    b = 14'($random(seed) % 1500);
    if (md == 2) b = 14'h3d44;
    if (md == 3) b = 14'h1fff;
    pend.code[0] = a;
    pend.code[1] = b;
    if (md == 1 || md == 2) q.push_back(28'h000_0000);
    else q.push_back({calc(a, off_a, gn_a), calc(b, off_b, gn_b)});
    host.frame({ad, d});
    repeat (20) @(posedge clk);
    case (ad)
      4'h2: off_a = d;
      4'h3: off_b = d;
      4'h4: gn_a = d[11:5];
      4'h5: gn_b = d[11:5];
      default: ;
    endcase
    if (md == 2) begin
      off_a = sm(a);
      off_b = sm(b);
    end
    $display("frame done addr %h mode %0d", ad, md);
  endtask
  // result watcher: oldest note against each finished frame
  initial forever begin
    @(host.done);
    expv = q.size() != 0 ? q.pop_front() : 'x;
    check("line_a", expv, host.cap_a);
    check("line_b", {expv[13:0], expv[27:14]}, host.cap_b);
    #1;
    check("line_oe", 28'h3, 28'({oe_a_n, oe_b_n}));
  end
  // prints counts and verdict, ends the run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    seed = 32'hbfb8_cf1d;
    {num_errors, tests_run, cyc} = '0;
    pend = '0;
    {off_a, off_b, gn_a, gn_b} = '0;
    powered = 1'b1;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(4'h0, 12'h000, 0);
    xfer(4'h2, 12'h841, 0);
    xfer(4'h3, host.to_offset(14'h0041), 0);
    xfer(4'h4, 12'h7e0, 0);
    xfer(4'h5, 12'hfe0, 0);
    xfer(4'h0, 12'h000, 3);
    host.set_cal(1'b1);
    xfer(4'h0, 12'h000, 1);
    xfer(4'h0, 12'h000, 2);
    check("short_inputs", 28'h1, 28'(short_seen));
    check("cal_active", 28'h0, 28'(cal_active));
    host.set_cal(1'b0);
    xfer(4'h0, 12'h000, 0);
    xfer(4'h1, 12'h003, 0);
    check("pga_gain", 28'h3, 28'(pga_gain));
    xfer(4'h0, 12'h000, 0);
    xfer(4'h1, 12'h013, 1);
    powered <= 1'b0;
    xfer(4'h0, 12'h000, 1);
    powered <= 1'b1;
    xfer(4'h0, 12'h000, 2);
    xfer(4'h0, 12'h000, 0);
    finish_test;
  end
endmodule

// ### test/host_port_model.sv
`timescale 1ns/10ps
// host side of the link: frames, writes, captures both result lines
module host_port_model (
  // link pins towards the block
  output logic      sclk,
  output logic      cs_n,
  output logic      cal_pin,
  output logic      host_data_line,
  // result lines from the block
  input  wire logic result_line_a,
  input  wire logic result_line_b
);
  import adc_cal_pkg::*;
  logic [27:0] cap_a; // two words seen on line a
  logic [27:0] cap_b; // two words seen on line b
  event        done;  // frame finished
  // link idles with clock high and frame select high
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    cal_pin = 1'b0;
    host_data_line = 1'b0;
  end
  // calibrate request moves only while frame select is high
  task automatic set_cal(input logic v);
    if (cs_n) cal_pin = v;
  endtask
  // trims a 14-bit code to the offset register width
  function automatic logic [11:0] to_offset(input logic [13:0] r);
    return {r[13], r[10:0]};
  endfunction
  // one 47-edge frame; clock stands still outside it
  task automatic frame(input wr_word_t w);
    logic [15:0] b;
    b = w;
    host_data_line = b[15];
    cs_n = 1'b0;
    #62.5;
    for (int e = 1; e <= 47; e++) begin
      sclk = 1'b0;
      #62.5;
      sclk = 1'b1;
      if (e >= 19 && e <= 46) begin
        cap_a = {cap_a[26:0], result_line_a};
        cap_b = {cap_b[26:0], result_line_b};
      end
      host_data_line = (e < 16) ? b[15-e] : 1'b0;
      #62.5;
    end
    cs_n = 1'b1;
    ->done;
    #400;
  endtask
endmodule
